/* File: common/cbt_pkg.sv */
// Purpose: Shared constants for the calendar clock with backup and tamper
// Assumes: 40 MHz ref_clk, byte addressed word aligned register map
// Notes:   Cycle counts derive from the clock rate below
package cbt_pkg;
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SUBSEC_STEPS  = 256;
  localparam int SUBSEC_CYC    = CLK_HZ / SUBSEC_STEPS;
  localparam int CAL_OUT_HZ    = 512;
  localparam int CAL_HALF_CYC  = CLK_HZ / (2 * CAL_OUT_HZ);
  localparam int WUT_STEP_NS   = 120_000;
  localparam int WUT_STEP_CYC  = WUT_STEP_NS / CLK_PERIOD_NS;
  localparam int WAKE_MAX_NS   = 8_000;
  localparam int WAKE_MAX_CYC  = WAKE_MAX_NS / CLK_PERIOD_NS;
  localparam int NUM_BKP       = 20;
  localparam int NUM_TAMP      = 3;
  localparam int TAMP_FILT     = 4;
  localparam logic [5:0] REF50_LAST = 6'h31;
  localparam logic [5:0] REF60_LAST = 6'h3B;
  localparam logic [7:0] SUBSEC_TOP = 8'hFF;

  // Register byte offsets
  localparam logic [7:0] OFS_TIME   = 8'h00;
  localparam logic [7:0] OFS_DATE   = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_SUBSEC = 8'h0C;
  localparam logic [7:0] OFS_SHIFT  = 8'h10;
  localparam logic [7:0] OFS_CAL    = 8'h14;
  localparam logic [7:0] OFS_WUT    = 8'h18;
  localparam logic [7:0] OFS_ALM0   = 8'h1C;
  localparam logic [7:0] OFS_ALM1   = 8'h20;
  localparam logic [7:0] OFS_TSTIME = 8'h24;
  localparam logic [7:0] OFS_TSDATE = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_MASK   = 8'h30;
  localparam logic [7:0] OFS_BKP    = 8'h40;

  // Field masks and reset values
  localparam logic [31:0] TIME_MASK = 32'h007F_7F7F;
  localparam logic [31:0] DATE_MASK = 32'h00FF_FF3F;
  localparam logic [31:0] TIME_RST  = 32'h0000_0000;
  localparam logic [31:0] DATE_RST  = 32'h0000_2101;
  localparam logic [31:0] ALM_RST   = 32'h0000_0000;
  localparam logic [15:0] CTRL_RST  = 16'h0000;

  // Control bits
  localparam int C_FMT12 = 0;
  localparam int C_REFEN = 1;
  localparam int C_REF60 = 2;
  localparam int C_CALEN = 3;
  localparam int C_WUTEN = 4;
  localparam int C_WUT1S = 5;
  localparam int C_ALM0  = 6;
  localparam int C_TSEN  = 8;
  localparam int C_FILT  = 9;
  localparam int C_TAMP  = 12;

  // Status bits
  localparam int NUM_FLAGS = 7;
  localparam int ST_ALM0   = 0;
  localparam int ST_WUT    = 2;
  localparam int ST_TS     = 3;
  localparam int ST_TAMP   = 4;
endpackage : cbt_pkg

/* File: logic/cbt_top.sv */
// Purpose: Calendar clock with alarms, wakeup timer, stamp and tamper
// Assumes: One clock kept alive in low-power modes, Avalon-MM slave
// Notes:   One wait state on every bus access
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Binary sub-second and BCD second to year counters, hour in 12 or 24 hour format
// - Date rolls over after 28, 29, 30 or 31 days by itself
// - Two alarms each flag an event when the calendar matches
// - Periodic wakeup timer from 120 us up to 36 hours
// - Alarm and wakeup events can wake from Stop and Standby
// - A 512 Hz output lets the clock rate be measured
// - Signed digital trim offsets crystal drift each second
// - Seconds may follow a 50 or 60 Hz mains reference input
// - Software shifts the running calendar by sub-second steps
// - Stamp pin edge captures time and date and flags it
// - Twenty 32-bit backup words hold user data
// - A tamper event clears every backup word
// - Three tamper pins; a change clears backups and flags
// - Each tamper pin has an optional glitch filter
// - Calendar keeps counting while core clocks are stopped
// - Alarm, tamper, stamp and timer drive wake lines within 8 us
// - Events leave on dedicated lines apart from pin lines
module cbt_top #(
  parameter int SUBSEC_CYC   = cbt_pkg::SUBSEC_CYC,
  parameter int CAL_HALF_CYC = cbt_pkg::CAL_HALF_CYC,
  parameter int WUT_STEP_CYC = cbt_pkg::WUT_STEP_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Register bus
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins
  input  wire logic [2:0]  tamp_pin,
  input  wire logic        stamp_pin,
  input  wire logic        mains_ref,
  output logic             cal_out,
  // Interrupt and event-controller lines
  output logic             irq,
  output logic             wake_alarm,
  output logic             wake_tamper,
  output logic             wake_stamp,
  output logic             wake_timer
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic [31:0] time_ff, date_ff, tst_ff, tsd_ff, rdata_ff;
  logic [31:0] nxt_time, nxt_date, nxt_tst, nxt_tsd, nxt_rdata;
  logic [31:0] alm_ff [2];
  logic [31:0] nxt_alm [2];
  logic [31:0] bkp_ff [cbt_pkg::NUM_BKP];
  logic [31:0] nxt_bkp [cbt_pkg::NUM_BKP];
  logic [15:0] ctrl_ff, nxt_ctrl, calo_ff, nxt_calo;
  logic [17:0] presc_ff, nxt_presc;
  logic [16:0] wut_rld_ff, nxt_wut_rld, wut_cnt_ff, nxt_wut_cnt;
  logic [12:0] wdiv_ff, nxt_wdiv;
  logic [8:0]  cal_ff, nxt_cal;
  logic [7:0]  subsec_ff, nxt_subsec;
  logic [6:0]  sts_ff, nxt_sts, msk_ff, nxt_msk, evt_ff, ev_now;
  logic [5:0]  refcnt_ff, nxt_refcnt;
  logic        ack_ff, ref_prev_ff, ts_prev_ff, cal_out_ff, chk_ff;
  logic        nxt_cal_out;
  logic        req, wr, sec_tick, wut_tick, ref_edge;
  logic [1:0]  alm_hit;
  logic [2:0]  tamp_ev;
  logic [4:0]  bkp_idx;
  logic        bkp_sel;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  function automatic logic [7:0] last_day(input logic [7:0] mo,
                                          input logic [7:0] yr);
    logic leap;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                       yr[3:0] == 4'h8)) ||
           (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    unique case (mo)
      8'h02:                      last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
  endfunction : last_day

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? dat[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  // Bus slave: one wait state, write lands at the edge waitrequest is low
  assign req             = avs_read | avs_write;
  assign wr              = avs_write & ack_ff;
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign bkp_sel = (avs_address >= cbt_pkg::OFS_BKP) &&
                   (avs_address < cbt_pkg::OFS_BKP + 8'(4 * cbt_pkg::NUM_BKP));
  assign bkp_idx = 5'((avs_address - cbt_pkg::OFS_BKP) >> 2);

  // Mains edges and timebase ticks
  assign ref_edge = mains_ref & ~ref_prev_ff;
  assign wut_tick = ctrl_ff[cbt_pkg::C_WUT1S] ? sec_tick : (wdiv_ff == '0);

  // Alarm comparators; a set mask bit ignores that field
  for (genvar a = 0; a < 2; a++) begin : g_alm
    logic [31:0] av;
    assign av = alm_ff[a];
    assign alm_hit[a] = chk_ff && ctrl_ff[cbt_pkg::C_ALM0 + a] &&
      (av[7]  || av[6:0]   == time_ff[6:0])   &&
      (av[15] || av[14:8]  == time_ff[14:8])  &&
      (av[23] || av[22:16] == time_ff[22:16]) &&
      (av[31] || av[29:24] == date_ff[5:0]);
  end

  // Tamper pins with optional all-equal sample filter
  for (genvar t = 0; t < cbt_pkg::NUM_TAMP; t++) begin : g_tamp
    logic [cbt_pkg::TAMP_FILT-1:0] smp_ff, nxt_smp;
    logic lvl_ff, nxt_lvl, arm_ff;
    always_comb begin
      nxt_smp = {smp_ff[cbt_pkg::TAMP_FILT-2:0], tamp_pin[t]};
      nxt_lvl = lvl_ff;
      if (!ctrl_ff[cbt_pkg::C_FILT + t]) begin
        nxt_lvl = tamp_pin[t];
      end else if (&nxt_smp) begin
        nxt_lvl = 1'b1;
      end else if (~|nxt_smp) begin
        nxt_lvl = 1'b0;
      end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        smp_ff <= '0;
        lvl_ff <= 1'b0;
        arm_ff <= 1'b0;
      end else begin
        smp_ff <= nxt_smp;
        lvl_ff <= nxt_lvl;
        arm_ff <= 1'b1;
      end
    end
    assign tamp_ev[t] = arm_ff && ctrl_ff[cbt_pkg::C_TAMP + t] &&
                        (nxt_lvl != lvl_ff);
  end

  always_comb begin
    logic [7:0] s, m, h, d, mo, y;
    logic [2:0] wd;
    logic pm, day_c, shift_wr;
    logic [8:0] sub_sum;
    s = {1'b0, time_ff[6:0]};
    m = {1'b0, time_ff[14:8]};
    h = {2'b00, time_ff[21:16]};
    pm = time_ff[22];
    d = {2'b00, date_ff[5:0]};
    mo = {3'b000, date_ff[12:8]};
    wd = date_ff[15:13];
    y = date_ff[23:16];
    day_c = 1'b0;
    sub_sum = '0;
    shift_wr = wr && avs_address == cbt_pkg::OFS_SHIFT;
    nxt_ctrl = ctrl_ff; nxt_cal = cal_ff; nxt_wut_rld = wut_rld_ff;
    nxt_alm = alm_ff; nxt_msk = msk_ff; nxt_bkp = bkp_ff;
    nxt_tst = tst_ff; nxt_tsd = tsd_ff;
    nxt_subsec = subsec_ff; nxt_refcnt = refcnt_ff;
    sec_tick = 1'b0;
    // Free running timebase, never gated by core sleep state
    nxt_presc = presc_ff - 18'd1;
    if (presc_ff == '0) begin
      nxt_presc = 18'(SUBSEC_CYC - 1);
      if (subsec_ff == 8'h01) begin
        nxt_presc = 18'(SUBSEC_CYC - 1) + {{9{cal_ff[8]}}, cal_ff};
      end
      nxt_subsec = subsec_ff - 8'h01;
      if (subsec_ff == '0) begin
        nxt_subsec = cbt_pkg::SUBSEC_TOP;
        sec_tick = !ctrl_ff[cbt_pkg::C_REFEN];
      end
    end
    if (ctrl_ff[cbt_pkg::C_REFEN] && ref_edge) begin
      nxt_refcnt = refcnt_ff + 6'd1;
      if (refcnt_ff == (ctrl_ff[cbt_pkg::C_REF60] ? cbt_pkg::REF60_LAST
                                                 : cbt_pkg::REF50_LAST)) begin
        nxt_refcnt = '0;
        sec_tick = 1'b1;
        nxt_subsec = cbt_pkg::SUBSEC_TOP;
        nxt_presc = 18'(SUBSEC_CYC - 1);
      end
    end
    if (shift_wr) begin
      sub_sum = {1'b0, nxt_subsec} + {1'b0, avs_writedata[7:0]};
      nxt_subsec = sub_sum[8] ? cbt_pkg::SUBSEC_TOP : sub_sum[7:0];
      if (avs_writedata[31]) begin
        sec_tick = 1'b1;
      end
    end
    if (sec_tick) begin
      if (s != 8'h59) begin
        s = bcd_inc(s);
      end else begin
        s = 8'h00;
        if (m != 8'h59) begin
          m = bcd_inc(m);
        end else begin
          m = 8'h00;
          if (ctrl_ff[cbt_pkg::C_FMT12]) begin
            if (h == 8'h11) begin
              h = 8'h12;
              day_c = pm;
              pm = ~pm;
            end else begin
              h = (h == 8'h12) ? 8'h01 : bcd_inc(h);
            end
          end else if (h == 8'h23) begin
            h = 8'h00;
            day_c = 1'b1;
          end else begin
            h = bcd_inc(h);
          end
        end
      end
    end
    if (day_c) begin
      wd = (wd == 3'd7) ? 3'd1 : wd + 3'd1;
      if (d != last_day(mo, y)) begin
        d = bcd_inc(d);
      end else begin
        d = 8'h01;
        if (mo == 8'h12) begin
          mo = 8'h01;
          y = (y == 8'h99) ? 8'h00 : bcd_inc(y);
        end else begin
          mo = bcd_inc(mo);
        end
      end
    end
    nxt_time = {9'h000, pm, h[5:0], 1'b0, m[6:0], 1'b0, s[6:0]};
    nxt_date = {8'h00, y, wd, mo[4:0], 2'b00, d[5:0]};
    // Wakeup timer; a 17-bit reload at 1 s reaches 36 hours
    nxt_wdiv = (wdiv_ff == '0) ? 13'(WUT_STEP_CYC - 1) : wdiv_ff - 13'd1;
    nxt_wut_cnt = wut_cnt_ff;
    ev_now = '0;
    if (!ctrl_ff[cbt_pkg::C_WUTEN]) begin
      nxt_wut_cnt = wut_rld_ff;
    end else if (wut_tick) begin
      nxt_wut_cnt = wut_cnt_ff - 17'd1;
      if (wut_cnt_ff == '0) begin
        nxt_wut_cnt = wut_rld_ff;
        ev_now[cbt_pkg::ST_WUT] = 1'b1;
      end
    end
    ev_now[1:0] = alm_hit;
    ev_now[6:4] = tamp_ev;
    if (ctrl_ff[cbt_pkg::C_TSEN] && stamp_pin && !ts_prev_ff) begin
      ev_now[cbt_pkg::ST_TS] = 1'b1;
      nxt_tst = time_ff;
      nxt_tsd = date_ff;
    end
    nxt_sts = sts_ff;
    if (wr) begin
      unique case (avs_address)
        cbt_pkg::OFS_TIME: nxt_time = merge(nxt_time, avs_writedata,
                             avs_byteenable) & cbt_pkg::TIME_MASK;
        cbt_pkg::OFS_DATE: nxt_date = merge(nxt_date, avs_writedata,
                             avs_byteenable) & cbt_pkg::DATE_MASK;
        cbt_pkg::OFS_CTRL: nxt_ctrl = 16'(merge({16'h0, ctrl_ff},
                             avs_writedata, avs_byteenable));
        cbt_pkg::OFS_CAL: nxt_cal = avs_writedata[8:0];
        cbt_pkg::OFS_WUT: nxt_wut_rld = avs_writedata[16:0];
        cbt_pkg::OFS_ALM0: nxt_alm[0] = merge(alm_ff[0], avs_writedata,
                             avs_byteenable);
        cbt_pkg::OFS_ALM1: nxt_alm[1] = merge(alm_ff[1], avs_writedata,
                             avs_byteenable);
        cbt_pkg::OFS_STATUS: nxt_sts = sts_ff & ~avs_writedata[6:0];
        cbt_pkg::OFS_MASK: nxt_msk = avs_writedata[6:0];
        default: begin
          if (bkp_sel) begin
            nxt_bkp[bkp_idx] = merge(bkp_ff[bkp_idx], avs_writedata,
                                     avs_byteenable);
          end
        end
      endcase
    end
    nxt_sts = nxt_sts | ev_now;
    if (|tamp_ev) begin
      for (int i = 0; i < cbt_pkg::NUM_BKP; i++) begin
        nxt_bkp[i] = '0;
      end
    end
    // Read data registered in the wait cycle
    nxt_rdata = '0;
    if (req && !ack_ff && avs_read) begin
      unique case (avs_address)
        cbt_pkg::OFS_TIME:   nxt_rdata = time_ff;
        cbt_pkg::OFS_DATE:   nxt_rdata = date_ff;
        cbt_pkg::OFS_CTRL:   nxt_rdata = {16'h0, ctrl_ff};
        cbt_pkg::OFS_SUBSEC: nxt_rdata = {24'h0, subsec_ff};
        cbt_pkg::OFS_CAL:    nxt_rdata = {23'h0, cal_ff};
        cbt_pkg::OFS_WUT:    nxt_rdata = {15'h0, wut_rld_ff};
        cbt_pkg::OFS_ALM0:   nxt_rdata = alm_ff[0];
        cbt_pkg::OFS_ALM1:   nxt_rdata = alm_ff[1];
        cbt_pkg::OFS_TSTIME: nxt_rdata = tst_ff;
        cbt_pkg::OFS_TSDATE: nxt_rdata = tsd_ff;
        cbt_pkg::OFS_STATUS: nxt_rdata = {25'h0, sts_ff};
        cbt_pkg::OFS_MASK:   nxt_rdata = {25'h0, msk_ff};
        default:             nxt_rdata = bkp_sel ? bkp_ff[bkp_idx] : '0;
      endcase
    end
    // 512 Hz measurement output
    nxt_calo = (calo_ff == '0) ? 16'(CAL_HALF_CYC - 1) : calo_ff - 16'd1;
    nxt_cal_out = !ctrl_ff[cbt_pkg::C_CALEN] ? 1'b0 :
                  (calo_ff == '0) ? ~cal_out_ff : cal_out_ff;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      time_ff <= cbt_pkg::TIME_RST;
      date_ff <= cbt_pkg::DATE_RST;
      ctrl_ff <= cbt_pkg::CTRL_RST;
      alm_ff <= '{cbt_pkg::ALM_RST, cbt_pkg::ALM_RST};
      bkp_ff <= '{default: 32'h0000_0000};
      tst_ff <= '0; tsd_ff <= '0; rdata_ff <= '0;
      cal_ff <= '0; wut_rld_ff <= '0; wut_cnt_ff <= '0;
      presc_ff <= '0; wdiv_ff <= '0; calo_ff <= '0;
      subsec_ff <= cbt_pkg::SUBSEC_TOP; refcnt_ff <= '0;
      sts_ff <= '0; msk_ff <= '0; evt_ff <= '0;
      ack_ff <= 1'b0; ref_prev_ff <= 1'b0; ts_prev_ff <= 1'b0;
      cal_out_ff <= 1'b0; chk_ff <= 1'b0;
    end else begin
      time_ff <= nxt_time; date_ff <= nxt_date; ctrl_ff <= nxt_ctrl;
      alm_ff <= nxt_alm; bkp_ff <= nxt_bkp;
      tst_ff <= nxt_tst; tsd_ff <= nxt_tsd; rdata_ff <= nxt_rdata;
      cal_ff <= nxt_cal; wut_rld_ff <= nxt_wut_rld;
      wut_cnt_ff <= nxt_wut_cnt; presc_ff <= nxt_presc;
      wdiv_ff <= nxt_wdiv; calo_ff <= nxt_calo;
      subsec_ff <= nxt_subsec; refcnt_ff <= nxt_refcnt;
      sts_ff <= nxt_sts; msk_ff <= nxt_msk; evt_ff <= ev_now;
      ack_ff <= req & ~ack_ff;
      ref_prev_ff <= mains_ref; ts_prev_ff <= stamp_pin;
      cal_out_ff <= nxt_cal_out; chk_ff <= sec_tick;
    end
  end

  // Dedicated event-controller lines, one cycle after the event
  assign wake_alarm  = evt_ff[0] | evt_ff[1];
  assign wake_timer  = evt_ff[cbt_pkg::ST_WUT];
  assign wake_stamp  = evt_ff[cbt_pkg::ST_TS];
  assign wake_tamper = |evt_ff[6:4];
  assign irq         = |(sts_ff & msk_ff);
  assign cal_out     = cal_out_ff;

  sec_wrap_a: assert property (
    sec_tick && time_ff[6:0] == 7'h59 && !(wr && avs_address != 8'h10)
    |=> time_ff[6:0] == 7'h00)
    else $error("seconds did not wrap");
  feb_end_a: assert property (
    sec_tick && time_ff[22:0] == 23'h23_5959 && date_ff[12:0] == 13'h0228 &&
    date_ff[23:16] == 8'h23 && !ctrl_ff[0] && !(wr && avs_address != 8'h10)
    |=> date_ff[12:0] == 13'h0301)
    else $error("February end not rolled");
  alarm_flag_a: assert property (
    alm_hit[1] |=> sts_ff[1] ##0 wake_alarm)
    else $error("alarm hit lost");
  wut_fire_a: assert property (
    ctrl_ff[4] && wut_tick && wut_cnt_ff == '0
    |=> sts_ff[2] && wut_cnt_ff == wut_rld_ff)
    else $error("wakeup timer event lost");
  cal_idle_a: assert property (
    !ctrl_ff[3] |=> !cal_out)
    else $error("calibration output runs while disabled");
  stamp_cap_a: assert property (
    ev_now[3] |=> tst_ff == $past(time_ff) && sts_ff[3])
    else $error("stamp not captured");
  bkp_wipe_a: assert property (
    |tamp_ev |=> bkp_ff[0] == '0 && bkp_ff[19] == '0 && wake_tamper)
    else $error("backup not cleared on tamper");
  flag_hold_a: assert property (
    sts_ff[0] && !(wr && avs_address == 8'h2C && avs_writedata[0])
    |=> sts_ff[0])
    else $error("sticky flag dropped");
  wake_time_a: assert property (
    ev_now[2] |-> ##[1:2] wake_timer)
    else $error("wake line late");
endmodule : cbt_top

`default_nettype wire

/* File: verification/cbt_pin_model.sv */
// Purpose: Pin-side model for the tamper, stamp and mains lines
// Assumes: Flip and stamp commands are one-cycle pulses; mains_en is a level
// Notes:   A glitch inverts a tamper pin for one cycle only
`timescale 1ns/1ps
`default_nettype none
module cbt_pin_model #(
  parameter int MAINS_HALF = 8
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Commands from the bench
  input  wire logic [2:0] tamp_flip,
  input  wire logic       tamp_glitch,
  input  wire logic       stamp_go,
  input  wire logic       mains_en,
  // Pins toward the block
  output logic      [2:0] tamp_pin,
  output logic            stamp_pin,
  output logic            mains_ref,
  output int              mains_edges
);
  logic [2:0] undo_ff;
  logic [1:0] hold_ff;
  int         ph_ff;

  // Pins move just after an edge, as a source synchronous to ref_clk
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tamp_pin    <= 3'h0;
      undo_ff     <= 3'h0;
      hold_ff     <= 2'h0;
      stamp_pin   <= 1'b0;
      ph_ff       <= 0;
      mains_ref   <= 1'b0;
      mains_edges <= 0;
    end else begin
      tamp_pin    <= tamp_pin ^ tamp_flip ^ undo_ff;
      undo_ff     <= tamp_glitch ? tamp_flip : 3'h0;
      hold_ff     <= stamp_go ? 2'h3 : hold_ff - 2'(hold_ff != 2'h0);
      stamp_pin   <= stamp_go || hold_ff != 2'h0;
      ph_ff       <= (!mains_en || ph_ff == 2 * MAINS_HALF - 1) ?
                     0 : ph_ff + 1;
      mains_ref   <= mains_en && ph_ff >= MAINS_HALF;
      if (mains_en && ph_ff == MAINS_HALF) mains_edges <= mains_edges + 1;
    end
  end
endmodule : cbt_pin_model
`default_nettype wire

/* File: verification/test_calendar_clock_backup_tamper.sv */
// Purpose: Self-checking bench for the calendar clock block
// Assumes: Shortened sub-second, calibration output and wakeup step counts
// Notes:   Registers reached only through Avalon tasks
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_calendar_clock_backup_tamper;
  localparam int WS = 8;
  logic        ref_clk, arst_n, avs_read, avs_write, stamp_go;
  logic        tamp_glitch, mains_en, stamp_pin, mains_ref, cal_q;
  logic        avs_waitrequest, cal_out, irq, wake_alarm, wake_tamper;
  logic        wake_stamp, wake_timer;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [2:0]  tamp_pin, tamp_flip;
  int          bad_count, compares, cyc, wk[3], wt_last, wt_gap;
  int          cal_last, cal_gap, mains_edges, c0, e0;
  // Date in, time in, time out (seconds masked), date out
  logic [31:0] tab [8][4] = '{
    '{32'h0023_2228, 32'h0023_5959, 32'h0, 32'h0023_4301},
    '{32'h0024_2228, 32'h0023_5959, 32'h0, 32'h0024_4229},
    '{32'h0024_6229, 32'h0023_5959, 32'h0, 32'h0024_8301},
    '{32'h0023_C430, 32'h0023_5959, 32'h0, 32'h0023_E501},
    '{32'h0023_E131, 32'h0023_5959, 32'h0, 32'h0023_2201},
    '{32'h0099_5231, 32'h0023_5959, 32'h0, 32'h0000_6101},
    '{32'h0000_2101, 32'h0011_5959, 32'h0052_0000, 32'h0000_2101},
    '{32'h0000_2101, 32'h0051_5959, 32'h0012_0000, 32'h0000_4102}};

  cbt_top #(.SUBSEC_CYC(4), .CAL_HALF_CYC(4), .WUT_STEP_CYC(WS)) uut (
    .ref_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tamp_pin, .stamp_pin, .mains_ref, .cal_out, .irq, .wake_alarm,
    .wake_tamper, .wake_stamp, .wake_timer);
  cbt_pin_model #(.MAINS_HALF(8)) pins (
    .ref_clk, .arst_n, .tamp_flip, .tamp_glitch, .stamp_go, .mains_en,
    .tamp_pin, .stamp_pin, .mains_ref, .mains_edges);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts wake pulses and measures timer periods and calibration half periods
  always @(posedge ref_clk) begin
    cyc++;
    if (wake_alarm === 1'b1) wk[0]++;
    if (wake_tamper === 1'b1) wk[1]++;
    if (wake_stamp === 1'b1) wk[2]++;
    if (wake_timer === 1'b1) begin
      wt_gap = cyc - wt_last;
      wt_last = cyc;
    end
    if (cal_out !== cal_q) begin
      cal_gap = cyc - cal_last;
      cal_last = cyc;
    end
    cal_q = cal_out;
  end

  task automatic acc(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic w);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !w;
    avs_write      <= w;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(a, d, 4'hF, 1'b1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(a, 32'h0, 4'hF, 1'b0);
    `CHK(rd, e)
  endtask : rdc

  function automatic logic [7:0] ba(input int i);
    return cbt_pkg::OFS_BKP + 8'(4 * i);
  endfunction : ba

  task automatic tamp(input int p, input logic g);
    tamp_glitch <= g;
    tamp_flip   <= 3'(1 << p);
    @(posedge ref_clk);
    tamp_flip   <= 3'h0;
    repeat (10) @(posedge ref_clk);
  endtask : tamp

  // Polls until the seconds field moves
  task automatic wait_sec();
    logic [6:0] s;
    int n;
    acc(cbt_pkg::OFS_TIME, 32'h0, 4'hF, 1'b0);
    s = rd[6:0];
    for (n = 0; n < 3000 && rd[6:0] === s; n++)
      acc(cbt_pkg::OFS_TIME, 32'h0, 4'hF, 1'b0);
  endtask : wait_sec

  task automatic sec_len();
    wait_sec();
    c0 = cyc;
    e0 = mains_edges;
    wait_sec();
    c0 = cyc - c0;
    e0 = mains_edges - e0;
  endtask : sec_len

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    tamp_flip = 3'h0;
    tamp_glitch = 1'b0;
    stamp_go = 1'b0;
    mains_en = 1'b0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(cbt_pkg::OFS_TIME, cbt_pkg::TIME_RST);
    rdc(cbt_pkg::OFS_DATE, cbt_pkg::DATE_RST);
    rdc(8'h3C, 32'h0);
    rdc(cbt_pkg::OFS_SHIFT, 32'h0);
    for (int i = 0; i < 20; i++) wr(ba(i), 32'hA500_0000 | 32'(i));
    acc(ba(0), 32'hFFFF_FFFF, 4'h2, 1'b1);
    rdc(ba(0), 32'hA500_FF00);
    for (int i = 1; i < 20; i++) rdc(ba(i), 32'hA500_0000 | 32'(i));
    for (int p = 0; p < 3; p++) begin
      wr(cbt_pkg::OFS_CTRL, 32'h1200 << p);
      wr(cbt_pkg::OFS_MASK, 32'h10 << p);
      tamp(p, 1'b1);
      rdc(cbt_pkg::OFS_STATUS, 32'h0);
      rdc(ba(1), 32'hA500_0001);
      tamp(p, 1'b0);
      `CHK(irq, 1'b1)
      `CHK(wk[1], p + 1)
      rdc(cbt_pkg::OFS_STATUS, 32'h10 << p);
      for (int i = 0; i < 20; i++) rdc(ba(i), 32'h0);
      wr(cbt_pkg::OFS_STATUS, 32'h10 << p);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 20; i++) wr(ba(i), 32'hA500_0000 | 32'(i));
    end
    for (int k = 0; k < 2; k++) begin
      wr(cbt_pkg::OFS_CTRL, 32'h40 << k);
      wr(cbt_pkg::OFS_MASK, 32'h1 << k);
      wr(cbt_pkg::OFS_ALM0 + 8'(4 * k), 32'h8080_8005);
      wr(cbt_pkg::OFS_TIME, 32'h0000_0004);
      for (int n = 0; n < 2500 && irq !== 1'b1; n++) @(posedge ref_clk);
      rdc(cbt_pkg::OFS_TIME, 32'h0000_0005);
      `CHK(wk[0], k + 1)
      rdc(cbt_pkg::OFS_STATUS, 32'h1 << k);
      wr(cbt_pkg::OFS_STATUS, 32'h1 << k);
      `CHK(irq, 1'b0)
    end
    wr(cbt_pkg::OFS_WUT, 32'h3);
    wr(cbt_pkg::OFS_CTRL, 32'h10);
    repeat (100) @(posedge ref_clk);
    `CHK(wt_gap, 4 * WS)
    rdc(cbt_pkg::OFS_STATUS, 32'h4);
    wr(cbt_pkg::OFS_CTRL, 32'h0);
    wr(cbt_pkg::OFS_WUT, 32'h0);
    wr(cbt_pkg::OFS_CTRL, 32'h30);
    repeat (2200) @(posedge ref_clk);
    `CHK(wt_gap, 256 * 4)
    wr(cbt_pkg::OFS_CTRL, 32'h108);
    wr(cbt_pkg::OFS_STATUS, 32'h7F);
    wr(cbt_pkg::OFS_DATE, 32'h0024_4229);
    wr(cbt_pkg::OFS_TIME, 32'h0012_3456);
    stamp_go <= 1'b1;
    @(posedge ref_clk);
    stamp_go <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK(cal_gap, 4)
    acc(cbt_pkg::OFS_TSTIME, 32'h0, 4'hF, 1'b0);
    `CHK(rd & 32'h007F_FF00, 32'h0012_3400)
    rdc(cbt_pkg::OFS_TSDATE, 32'h0024_4229);
    rdc(cbt_pkg::OFS_STATUS, 32'h8);
    `CHK(wk[2], 1)
    for (int r = 0; r < 8; r++) begin
      wr(cbt_pkg::OFS_CTRL, (r > 5) ? 32'h1 : 32'h0);
      wr(cbt_pkg::OFS_DATE, tab[r][0]);
      wr(cbt_pkg::OFS_TIME, tab[r][1]);
      wr(cbt_pkg::OFS_SHIFT, 32'h8000_0000);
      acc(cbt_pkg::OFS_TIME, 32'h0, 4'hF, 1'b0);
      `CHK(rd & 32'h007F_FF00, tab[r][2])
      rdc(cbt_pkg::OFS_DATE, tab[r][3]);
    end
    mains_en <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(cbt_pkg::OFS_CTRL, 32'h2 | (32'(m) << 2));
      sec_len();
      `CHK(e0, 50 + 10 * m)
    end
    mains_en <= 1'b0;
    wr(cbt_pkg::OFS_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(cbt_pkg::OFS_CAL, k ? 32'h1FD : 32'h20);
      sec_len();
      `CHK((c0 + 35 * k) inside {[1053:1059]}, 1'b1)
    end
    print_verdict();
  end
endmodule : test_calendar_clock_backup_tamper
`default_nettype wire
